// ==== sfb_pkg.sv ====
package sfb_pkg;

  // ---------------------------------------------------------------
  // data memory layout
  // ---------------------------------------------------------------
  localparam int NBANK = 32;
  localparam int PERI_N = 20;
  localparam int GRAM_N = 80;
  localparam int GRAM_BANKS = 3;
  localparam int SHR_N = 16;
  localparam int LIN_N = GRAM_BANKS * GRAM_N;
  localparam logic [6:0] PERI_LO = 7'h0C;
  localparam logic [6:0] PERI_HI = 7'h1F;
  localparam logic [6:0] GRAM_LO = 7'h20;
  localparam logic [6:0] SHR_LO = 7'h70;
  localparam logic [4:0] GRAM_BANK_TOP = 5'h03;
  localparam logic [15:0] LIN_BASE = 16'h2000;
  localparam logic [15:0] LIN_TOP = 16'h20F0;
  localparam logic [15:0] PTR_DATA_TOP = 16'h1000;

  // ---------------------------------------------------------------
  // core register offsets within a bank
  // ---------------------------------------------------------------
  localparam logic [6:0] OFF_IND0 = 7'h00;
  localparam logic [6:0] OFF_IND1 = 7'h01;
  localparam logic [6:0] OFF_FLAGS = 7'h03;
  localparam logic [6:0] OFF_PTR0L = 7'h04;
  localparam logic [6:0] OFF_PTR1H = 7'h07;
  localparam logic [6:0] OFF_BANKSEL = 7'h08;
  localparam logic [6:0] OFF_WREG = 7'h09;

  // ---------------------------------------------------------------
  // flag register fields and reset values
  // ---------------------------------------------------------------
  localparam int FL_EXP = 4;
  localparam int FL_SLP = 3;
  localparam int FL_Z = 2;
  localparam int FL_NIB = 1;
  localparam int FL_C = 0;
  localparam logic [7:0] FLAGS_POR = 8'h18;

  // ---------------------------------------------------------------
  // bus
  // ---------------------------------------------------------------
  localparam logic [15:0] AXI_TOP = 16'h4000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    OP_ADD = 4'b0000,
    OP_SUB = 4'b0001,
    OP_AND = 4'b0010,
    OP_IOR = 4'b0011,
    OP_XOR = 4'b0100,
    OP_MOVE = 4'b0101,
    OP_ROTL = 4'b0110,
    OP_ROTR = 4'b0111,
    OP_PASS = 4'b1000
  } sfb_op_t;

  typedef enum logic [2:0] {
    RG_NONE = 3'b000,
    RG_CORE = 3'b001,
    RG_PERI = 3'b010,
    RG_GRAM = 3'b011,
    RG_SHR = 3'b100
  } sfb_region_t;

  typedef struct packed {
    sfb_region_t region;
    logic [9:0] idx;
    logic [6:0] off;
  } sfb_target_t;

endpackage : sfb_pkg

// ==== sfb_alu_if.sv ====
`timescale 1ns/1ps
interface sfb_alu_if;
  import sfb_pkg::*;
  sfb_op_t op;
  logic [7:0] a;
  logic [7:0] b;
  logic c_in;
  logic [7:0] result;
  logic z;
  logic dc;
  logic c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  modport calc (input op, a, b, c_in,
    output result, z, dc, c, upd_z, upd_dc, upd_c);
  modport core (output op, a, b, c_in,
    input result, z, dc, c, upd_z, upd_dc, upd_c);
endinterface : sfb_alu_if

// ==== sfb_alu.sv ====
`timescale 1ns/1ps
module sfb_alu (
  sfb_alu_if.calc alu
);
  import sfb_pkg::*;

  always_comb begin
    logic [7:0] opb;
    logic cin;
    logic [8:0] sum;
    logic [4:0] nib;
    opb = 8'h00;
    cin = 1'b0;
    sum = 9'h000;
    nib = 5'h00;
    opb = (alu.op == OP_SUB) ? ~alu.b : alu.b;
    cin = (alu.op == OP_SUB);
    sum = {1'b0, alu.a} + {1'b0, opb} + {8'h00, cin};
    nib = {1'b0, alu.a[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    alu.result = alu.a;
    alu.upd_z = 1'b0;
    alu.upd_dc = 1'b0;
    alu.upd_c = 1'b0;
    alu.dc = nib[4];
    alu.c = sum[8];
    unique case (alu.op)
      OP_ADD, OP_SUB: begin
        alu.result = sum[7:0];
        alu.upd_z = 1'b1;
        alu.upd_dc = 1'b1;
        alu.upd_c = 1'b1;
      end
      OP_AND: begin
        alu.result = alu.a & alu.b;
        alu.upd_z = 1'b1;
      end
      OP_IOR: begin
        alu.result = alu.a | alu.b;
        alu.upd_z = 1'b1;
      end
      OP_XOR: begin
        alu.result = alu.a ^ alu.b;
        alu.upd_z = 1'b1;
      end
      OP_MOVE: begin
        alu.upd_z = 1'b1;
      end
      OP_ROTL: begin
        alu.result = {alu.a[6:0], alu.c_in};
        alu.c = alu.a[7];
        alu.upd_c = 1'b1;
      end
      OP_ROTR: begin
        alu.result = {alu.c_in, alu.a[7:1]};
        alu.c = alu.a[0];
        alu.upd_c = 1'b1;
      end
      OP_PASS: begin
        alu.result = alu.a;
      end
      default: begin
        alu.result = alu.a;
      end
    endcase
    alu.z = (alu.result == 8'h00);
  end

endmodule : sfb_alu

// ==== sfb_status_mem.sv ====
`timescale 1ns/1ps
// Behaviour
// - flag register bits 7..5 always read zero
// - expiry flag set at power-up, watchdog kick and sleep
// - expiry flag cleared by a watchdog time-out
// - sleep flag set at power-up and by watchdog kick
// - sleep flag cleared when sleep executes
// - zero flag follows whether the ALU result is zero, except on rotates and pass-through
// - add/subtract set nibble carry from carry out of bit 3
// - add/subtract set carry from carry out of the msb
// - for subtraction carry flags mean no borrow
// - subtraction adds the two's complement of the second operand
// - rotates load carry with the bit shifted out
// - power-on sets expiry/sleep, clears arithmetic flags; warm reset keeps
// - peripheral bytes sit at offsets 0x0C..0x1F of every bank
// - each of banks 0..2 offers 80 bytes of general RAM
// - 16 shared bytes reachable from every bank
// - general RAM also reachable linearly through pointers
// - unimplemented data locations read zero
// - flag-updating writes to the flag register keep ALU flags
// - core registers fill the first 12 offsets of every bank
module sfb_status_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [15:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic warm_reset,
  input wire logic watchdog_kick_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic alu_valid,
  input wire sfb_pkg::sfb_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [6:0] alu_dest,
  input wire logic alu_dest_w,
  output logic [7:0] arith_reset_flags,
  output logic [7:0] alu_result,
  output logic [4:0] bank_sel
);
  import sfb_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] peri_mem [0:NBANK*PERI_N-1];
  logic [7:0] gram_mem [0:LIN_N-1];
  logic [7:0] shr_mem [0:SHR_N-1];
  logic [15:0] ptr [0:1];
  logic [7:0] wreg;
  logic [15:0] aw_addr;
  logic aw_held;
  logic [7:0] w_byte;
  logic w_lane;
  logic w_held;
  logic commit;
  logic aw_ok;
  logic ar_ok;
  logic wr_en;
  logic wr_from_alu;
  logic [7:0] wr_data;
  sfb_target_t wr_t;
  sfb_target_t rd_t;
  logic [7:0] rd_byte;
  logic flag_hit;
  logic alu_any_upd;

  sfb_alu_if alu_bus ();

  assign alu_bus.op = alu_op;
  assign alu_bus.a = alu_a;
  assign alu_bus.b = alu_b;
  assign alu_bus.c_in = arith_reset_flags[FL_C];

  sfb_alu u_alu (
    .alu(alu_bus)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic sfb_target_t map_addr(input logic [11:0] addr);
    sfb_target_t t;
    logic [6:0] off;
    logic [4:0] bank;
    off = addr[6:0];
    bank = addr[11:7];
    t.region = RG_NONE;
    t.idx = 10'h000;
    t.off = off;
    if (off < PERI_LO) begin
      t.region = RG_CORE;
    end else if (off <= PERI_HI) begin
      t.region = RG_PERI;
      t.idx = 10'(int'(bank) * PERI_N + int'(off - PERI_LO));
    end else if (off >= SHR_LO) begin
      t.region = RG_SHR;
      t.idx = 10'(off - SHR_LO);
    // general RAM in the low banks
    end else if (bank < GRAM_BANK_TOP) begin
      t.region = RG_GRAM;
      t.idx = 10'(int'(bank) * GRAM_N + int'(off - GRAM_LO));
    end
    return t;
  endfunction : map_addr

  function automatic sfb_target_t resolve(input logic [11:0] addr,
      input logic [15:0] p0, input logic [15:0] p1);
    sfb_target_t t;
    logic [15:0] p;
    t = map_addr(addr);
    p = 16'h0000;
    if (t.region == RG_CORE && t.off <= OFF_IND1) begin
      p = t.off[0] ? p1 : p0;
      if (p >= LIN_BASE && p < LIN_TOP) begin
        t.region = RG_GRAM;
        t.idx = 10'(p - LIN_BASE);
      end else if (p < PTR_DATA_TOP) begin
        t = map_addr(p[11:0]);
        // a pointer aimed at an indirect slot would loop; it reads zero
        if (t.region == RG_CORE && t.off <= OFF_IND1) begin
          t.region = RG_NONE;
        end
      end else begin
        t.region = RG_NONE;
      end
    end
    return t;
  endfunction : resolve

  // ---------------------------------------------------------------
  // single write port: ALU write-back wins over the bus
  // ---------------------------------------------------------------
  assign aw_ok = (aw_addr < AXI_TOP);
  assign ar_ok = (araddr < AXI_TOP);
  // the bus write waits while the ALU owns the write port
  assign commit = aw_held && w_held && !bvalid && !alu_valid;
  assign alu_any_upd = alu_bus.upd_z | alu_bus.upd_dc | alu_bus.upd_c;
  assign flag_hit = (wr_t.region == RG_CORE) && (wr_t.off == OFF_FLAGS);

  always_comb begin
    wr_en = 1'b0;
    wr_from_alu = 1'b0;
    wr_data = 8'h00;
    wr_t = resolve(aw_addr[13:2], ptr[0], ptr[1]);
    if (alu_valid) begin
      wr_t = resolve({bank_sel, alu_dest}, ptr[0], ptr[1]);
      wr_en = !alu_dest_w;
      wr_from_alu = 1'b1;
      wr_data = alu_bus.result;
    end else if (commit) begin
      wr_en = aw_ok && w_lane;
      wr_data = w_byte;
    end
  end

  // ---------------------------------------------------------------
  // arithmetic and reset flags
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arith_reset_flags <= FLAGS_POR;
    end else begin
      if (wr_en && flag_hit && !(wr_from_alu && alu_any_upd)) begin
        arith_reset_flags[2:0] <= wr_data[2:0];
      end
      if (alu_valid && alu_bus.upd_z) begin
        arith_reset_flags[FL_Z] <= alu_bus.z;
      end
      if (alu_valid && alu_bus.upd_dc) begin
        arith_reset_flags[FL_NIB] <= alu_bus.dc;
      end
      if (alu_valid && alu_bus.upd_c) begin
        arith_reset_flags[FL_C] <= alu_bus.c;
      end
      // expiry set by kick or sleep
      if (watchdog_kick_instr || sleep_instr) begin
        arith_reset_flags[FL_EXP] <= 1'b1;
      end else if (watchdog_timeout) begin
        arith_reset_flags[FL_EXP] <= 1'b0;
      end
      if (watchdog_kick_instr) begin
        arith_reset_flags[FL_SLP] <= 1'b1;
      end else if (sleep_instr) begin
        arith_reset_flags[FL_SLP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alu_result <= 8'h00;
    end else if (alu_valid) begin
      alu_result <= alu_bus.result;
    end
  end

  // ---------------------------------------------------------------
  // core registers other than the flags
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_sel <= 5'h00;
      ptr[0] <= 16'h0000;
      ptr[1] <= 16'h0000;
      wreg <= 8'h00;
    end else if (warm_reset) begin
      // warm reset leaves the flags alone
      bank_sel <= 5'h00;
      ptr[0] <= 16'h0000;
      ptr[1] <= 16'h0000;
    end else begin
      if (alu_valid && alu_dest_w) begin
        wreg <= alu_bus.result;
      end
      if (wr_en && wr_t.region == RG_CORE) begin
        if (wr_t.off >= OFF_PTR0L && wr_t.off <= OFF_PTR1H) begin
          ptr[wr_t.off[1]][{wr_t.off[0], 3'b000} +: 8] <= wr_data;
        end else if (wr_t.off == OFF_BANKSEL) begin
          bank_sel <= wr_data[4:0];
        end else if (wr_t.off == OFF_WREG) begin
          wreg <= wr_data;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // data memories (contents are not reset, as in plain RAM)
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (wr_en && wr_t.region == RG_PERI) begin
      peri_mem[wr_t.idx] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en && wr_t.region == RG_GRAM) begin
      gram_mem[wr_t.idx[7:0]] <= wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (wr_en && wr_t.region == RG_SHR) begin
      shr_mem[wr_t.idx[3:0]] <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rd_t = resolve(araddr[13:2], ptr[0], ptr[1]);
    rd_byte = 8'h00;
    if (ar_ok) begin
      unique case (rd_t.region)
        RG_PERI: rd_byte = peri_mem[rd_t.idx];
        RG_GRAM: rd_byte = gram_mem[rd_t.idx[7:0]];
        RG_SHR: rd_byte = shr_mem[rd_t.idx[3:0]];
        RG_CORE: begin
          if (rd_t.off == OFF_FLAGS) begin
            rd_byte = {3'b000, arith_reset_flags[4:0]};
          end else if (rd_t.off >= OFF_PTR0L && rd_t.off <= OFF_PTR1H) begin
            rd_byte = ptr[rd_t.off[1]][{rd_t.off[0], 3'b000} +: 8];
          end else if (rd_t.off == OFF_BANKSEL) begin
            rd_byte = {3'b000, bank_sel};
          end else if (rd_t.off == OFF_WREG) begin
            rd_byte = wreg;
          end
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // bus read channel
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {24'h000000, rd_byte};
      rresp <= ar_ok ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // bus write channels
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 16'h0000;
      w_byte <= 8'h00;
      w_lane <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (commit) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= aw_ok ? RESP_OKAY : RESP_DECERR;
      end
      // ready returns only after the response, one write at a time
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

endmodule : sfb_status_mem

// ==== sfb_status_mem_properties.sv ====
`timescale 1ns/1ps
module sfb_status_mem_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic watchdog_kick_instr,
  input wire logic sleep_instr,
  input wire logic watchdog_timeout,
  input wire logic alu_valid,
  input wire sfb_pkg::sfb_op_t alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  input wire logic [7:0] arith_reset_flags,
  input wire logic [7:0] alu_result
);
  import sfb_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hi; arith_reset_flags[7:5] == 3'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_por; $rose(aresetn) |-> arith_reset_flags == FLAGS_POR;
  endproperty
  a_por: assert property (p_por) else $error("bad reset flags");
  property p_kick; watchdog_kick_instr |=> arith_reset_flags[4:3] == 2'h3;
  endproperty
  a_kick: assert property (p_kick) else $error("kick flags");
  property p_sleep; sleep_instr && !watchdog_kick_instr |=>
    arith_reset_flags[4:3] == 2'h2; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep flags");
  property p_tmo; watchdog_timeout && !watchdog_kick_instr && !sleep_instr
    |=> !arith_reset_flags[4]; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout flag");
  // nibble sums are built by concatenation so each operand is widened to 5 bits first and the carry out of bit 3 is kept
  property p_add; alu_valid && alu_op == OP_ADD |=>
    {arith_reset_flags[0], alu_result} == $past({1'b0, alu_a} + alu_b) &&
    arith_reset_flags[1] ==
    $past(({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) >> 4);
  endproperty
  a_add: assert property (p_add) else $error("add flags");
  property p_sub; alu_valid && alu_op == OP_SUB |=>
    {arith_reset_flags[0], alu_result} ==
    $past({1'b0, alu_a} + {1'b0, ~alu_b} + 9'h001) &&
    arith_reset_flags[1] ==
    $past(({1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01) >> 4);
  endproperty
  a_sub: assert property (p_sub) else $error("sub flags");
  property p_zero; alu_valid && alu_op inside {OP_ADD, OP_SUB, OP_AND,
    OP_IOR, OP_XOR, OP_MOVE} |=> arith_reset_flags[2] == (alu_result == 0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag");
  property p_rot; alu_valid && alu_op == OP_ROTL |=>
    arith_reset_flags[0] == $past(alu_a[7]) &&
    alu_result == {$past(alu_a[6:0]), $past(arith_reset_flags[0])};
  endproperty
  a_rot: assert property (p_rot) else $error("rotate left");
  property p_rotr; alu_valid && alu_op == OP_ROTR |=>
    arith_reset_flags[0] == $past(alu_a[0]) &&
    alu_result == {$past(arith_reset_flags[0]), $past(alu_a[7:1])};
  endproperty
  a_rotr: assert property (p_rotr) else $error("rotate right");
endmodule : sfb_status_mem_props

bind sfb_status_mem sfb_status_mem_props u_props (.aclk(aclk),
  .aresetn(aresetn), .watchdog_kick_instr(watchdog_kick_instr),
  .sleep_instr(sleep_instr), .watchdog_timeout(watchdog_timeout),
  .alu_valid(alu_valid), .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b),
  .arith_reset_flags(arith_reset_flags), .alu_result(alu_result));

// ==== sfb_cpu_model.sv ====
`timescale 1ns/1ps
module sfb_cpu_model (
  input wire logic aclk,
  output logic alu_valid,
  output sfb_pkg::sfb_op_t alu_op,
  output logic [7:0] alu_a,
  output logic [7:0] alu_b,
  output logic [6:0] alu_dest,
  output logic alu_dest_w,
  output logic kick,
  output logic sleep,
  output logic tmo
);
  import sfb_pkg::*;
  initial begin
    {alu_valid, alu_a, alu_b, alu_dest, alu_dest_w} = '0;
    {kick, sleep, tmo} = '0;
    alu_op = OP_PASS;
  end
  // operands stop holding once the commit edge has passed
  task automatic issue(input sfb_op_t o, input logic [7:0] a,
      input logic [7:0] b, input logic [6:0] d, input logic dw);
    @(posedge aclk);
    alu_valid <= 1'b1;
    alu_op <= o;
    alu_a <= a;
    alu_b <= b;
    alu_dest <= d;
    alu_dest_w <= dw;
    @(posedge aclk);
    alu_valid <= 1'b0;
    alu_a <= ~a;
    alu_b <= ~b;
    @(negedge aclk);
  endtask : issue
  task automatic pulse(input logic k, input logic s, input logic t);
    @(posedge aclk);
    {kick, sleep, tmo} <= {k, s, t};
    @(posedge aclk);
    {kick, sleep, tmo} <= 3'h0;
  endtask : pulse
endmodule : sfb_cpu_model

// ==== status_flags_and_data_banks_tb.sv ====
`timescale 1ns/1ps
module status_flags_and_data_banks_tb;
  import sfb_pkg::*;
  localparam logic [15:0] FA = {7'h00, OFF_FLAGS, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, warm_reset;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_r, wr_r;
  logic alu_valid, alu_dest_w, kick, sleep, tmo;
  sfb_op_t alu_op;
  logic [7:0] alu_a, alu_b, arith_reset_flags, alu_result;
  logic [6:0] alu_dest;
  logic [4:0] bank_sel;
  int num_errors, comparisons, cycles;

  sfb_cpu_model CPU (.aclk(aclk), .alu_valid(alu_valid), .alu_op(alu_op),
    .alu_a(alu_a), .alu_b(alu_b), .alu_dest(alu_dest),
    .alu_dest_w(alu_dest_w), .kick(kick), .sleep(sleep), .tmo(tmo));
  sfb_status_mem DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .warm_reset(warm_reset), .watchdog_kick_instr(kick),
    .sleep_instr(sleep), .watchdog_timeout(tmo), .alu_valid(alu_valid),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_dest(alu_dest),
    .alu_dest_w(alu_dest_w), .arith_reset_flags(arith_reset_flags),
    .alu_result(alu_result), .bank_sel(bank_sel));

  always #25 aclk = ~aclk;
  // ----------------------------------------------------------------
  // bus master and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    wr_r = bresp;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd_d = rdata;
    rd_r = rresp;
  endtask : rd
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    rd(a);
    chk(rd_d, exp);
  endtask : rdchk
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alu();
    rdchk(FA, 32'h18);
    CPU.issue(OP_ADD, 8'h0F, 8'h01, 7'h20, 1'b0);
    chk(alu_result, 32'h10);
    rdchk(16'h0080, 32'h10);
    rdchk(FA, 32'h1A);
    CPU.issue(OP_SUB, 8'h05, 8'h05, 7'h20, 1'b1);
    rdchk(FA, 32'h1F);
    CPU.issue(OP_SUB, 8'h00, 8'h01, 7'h20, 1'b1);
    rdchk(FA, 32'h18);
    CPU.issue(OP_ROTL, 8'h81, 8'h00, 7'h20, 1'b1);
    chk(alu_result, 32'h02);
    rdchk(FA, 32'h19);
    CPU.issue(OP_ROTR, 8'h01, 8'h00, 7'h20, 1'b1);
    chk(alu_result, 32'h80);
    CPU.issue(OP_AND, 8'hF0, 8'h0F, 7'h20, 1'b1);
    rdchk(FA, 32'h1D);
    CPU.issue(OP_IOR, 8'h10, 8'h01, 7'h20, 1'b1);
    chk(alu_result, 32'h11);
    CPU.issue(OP_XOR, 8'h5A, 8'hA5, 7'h20, 1'b1);
    chk(alu_result, 32'hFF);
    rdchk(FA, 32'h19);
    CPU.issue(OP_MOVE, 8'h00, 8'h00, 7'h20, 1'b1);
    rdchk(FA, 32'h1D);
    // a pass-through must leave the zero flag alone
    CPU.issue(OP_PASS, 8'h80, 8'h00, 7'h20, 1'b1);
    chk(alu_result, 32'h80);
    rdchk(FA, 32'h1D);
    $display("t_alu done");
  endtask : t_alu
  task automatic t_events();
    CPU.pulse(1'b0, 1'b1, 1'b0);
    rdchk(FA, 32'h15);
    CPU.pulse(1'b0, 1'b0, 1'b1);
    rdchk(FA, 32'h05);
    CPU.pulse(1'b1, 1'b0, 1'b0);
    rdchk(FA, 32'h1D);
    CPU.pulse(1'b0, 1'b1, 1'b1);
    rdchk(FA, 32'h15);
    CPU.pulse(1'b1, 1'b0, 1'b1);
    rdchk(FA, 32'h1D);
    $display("t_events done");
  endtask : t_events
  task automatic t_flagwr();
    wr(FA, 8'hE2);
    chk(wr_r, RESP_OKAY);
    rdchk(FA, 32'h1A);
    CPU.issue(OP_ADD, 8'h00, 8'h00, OFF_FLAGS, 1'b0);
    rdchk(FA, 32'h1C);
    rdchk(16'h040C, 32'h1C);
    $display("t_flagwr done");
  endtask : t_flagwr
  task automatic t_map();
    wr(16'h0030, 8'h11);
    wr(16'h0230, 8'h22);
    rdchk(16'h0030, 32'h11);
    rdchk(16'h0230, 32'h22);
    wr(16'h01C0, 8'h33);
    rdchk(16'h0BC0, 32'h33);
    wr(16'h0680, 8'h44);
    rdchk(16'h0680, 32'h00);
    rdchk(16'h0008, 32'h00);
    rd(16'h4000);
    chk(rd_r, RESP_DECERR);
    wr(16'h4000, 8'h00);
    chk(wr_r, RESP_DECERR);
    wr(16'h0280, 8'hA5);
    wr(16'h0010, 8'h50);
    wr(16'h0014, 8'h20);
    rdchk(16'h0000, 32'hA5);
    $display("t_map done");
  endtask : t_map
  task automatic t_warm();
    wr(16'h0020, 8'h02);
    chk(bank_sel, 32'h02);
    @(posedge aclk);
    warm_reset <= 1'b1;
    @(posedge aclk);
    warm_reset <= 1'b0;
    @(negedge aclk);
    chk(bank_sel, 32'h00);
    rdchk(FA, 32'h1C);
    $display("t_warm done");
  endtask : t_warm

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, warm_reset} = '0;
    {num_errors, comparisons, cycles} = '0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_alu();
    t_events();
    t_flagwr();
    t_map();
    t_warm();
    conclude();
  end
endmodule : status_flags_and_data_banks_tb
